// ### include/dpc_defines.svh
/*
 * Named constants for the dual PLL clock serial control block: command
 * register map, serial frame layout and frame sync timing.
 * Assumes a single 25 MHz system clock.
 */
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// Serial frame layout: read/write flag, register address, data byte
`define DPC_ADDR_W 3
`define DPC_DATA_W 8
`define DPC_NUM_REGS 8
`define DPC_CNT_W 4
`define DPC_CMD_LAST 4'h3
`define DPC_DATA_LAST 4'h7
`define DPC_DATA_BITS 4'h8
`define DPC_RW_READ 1'b1

// Command register indices
`define DPC_REG_MODE 3'h0
`define DPC_REG_RATIO_ONE 3'h1
`define DPC_REG_RATIO_TWO 3'h2
`define DPC_REG_LOCK_SEL 3'h3
`define DPC_REG_OUT_CTRL 3'h4
`define DPC_REG_RESET 8'h00

// Field positions
`define DPC_MODE_MSB 2
`define DPC_LOCK_SEL_MSB 1
`define DPC_OUT_ONE_EN_BIT 0

// Lock indicator sources
`define DPC_LOCK_BOTH 2'h0
`define DPC_LOCK_ONE 2'h1
`define DPC_LOCK_TWO 2'h2

// Frame sync timing, half periods rounded down
`define DPC_CLK_HZ 25000000
`define DPC_SYNC_SLOW_HZ 8000
`define DPC_SYNC_FAST_HZ 64000
`define DPC_SYNC_CNT_W 12
`define DPC_SYNC_HALF_SLOW ((`DPC_CLK_HZ) / (2 * `DPC_SYNC_SLOW_HZ))
`define DPC_SYNC_HALF_FAST ((`DPC_CLK_HZ) / (2 * `DPC_SYNC_FAST_HZ))

// Reference divider
`define DPC_RATIO_W 8

`endif

// ### include/dpc_pkg.sv
/*
 * Types and decode helpers shared by the clock control block.
 * Assumes dpc_defines.svh is reachable by include path.
 */
`include "dpc_defines.svh"

package dpc_pkg;

	// The six operating modes, codes 6 and 7 are illegal
	typedef enum logic [`DPC_MODE_MSB:0] {
		DPC_FWD_MASTER,
		DPC_REV_MASTER,
		DPC_FRAC_REV_MASTER,
		DPC_E1T1_FWD_MASTER,
		DPC_HS_REVERSE,
		DPC_SLAVE
	} dpc_mode_t;

	// Serial port sequencer
	typedef enum logic [1:0] {
		DPC_SP_CMD,
		DPC_SP_WDATA,
		DPC_SP_RDATA,
		DPC_SP_DONE
	} dpc_sp_state_t;

	// Strap low forces slave; illegal codes fall back to forward master
	function automatic dpc_mode_t dpc_mode_decode(input logic [`DPC_MODE_MSB:0] code,
			input logic master);
		dpc_mode_t m;
		m = DPC_FWD_MASTER;
		if (!master) begin
			m = DPC_SLAVE;
		end else if (code <= DPC_SLAVE) begin
			m = dpc_mode_t'(code);
		end
		return m;
	endfunction : dpc_mode_decode

endpackage : dpc_pkg

// ### include/dpc_div_if.sv
/*
 * Carrier between the control logic and one reference divider.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
`include "dpc_defines.svh"

interface dpc_div_if;
	logic ref_rise;
	logic [`DPC_RATIO_W-1:0] ratio;
	logic clk_out;

	modport ctrl (output ref_rise, output ratio, input clk_out);
	modport div (input ref_rise, input ratio, output clk_out);
endinterface : dpc_div_if

// ### src/dpc_ratio_div.sv
/*
 * Divides the sampled reference by a programmable ratio to form one
 * synthesized clock. Assumes ref_rise is a one-cycle strobe per reference edge.
 */
`timescale 1ns/100ps
`include "dpc_defines.svh"

module dpc_ratio_div
	import dpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	dpc_div_if.div div_bus
);

	logic [`DPC_RATIO_W-1:0] cnt_r;
	logic out_r;

	// Output toggles every ratio+1 reference edges, so it follows the reference
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else if (div_bus.ref_rise) begin
			if (cnt_r >= div_bus.ratio) begin
				cnt_r <= '0;
				out_r <= ~out_r;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	assign div_bus.clk_out = out_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ref_derived_a: assert property ($changed(out_r) |-> $past(div_bus.ref_rise))
		else $error("synth output moved without a reference edge");

endmodule : dpc_ratio_div

// ### src/dpc_top.sv
/*
 * Serial control port, command registers, mode select, frame sync and
 * output gating of a dual PLL clock synthesizer.
 * Assumes all pins are synchronous to clk_i; analog PLLs sit outside.
 */
// What this block does
// - Reads shift addressed register out serially
// - Read data changes only at shift falling edges
// - Output released after read data completes
// - Frame sync 8 kHz outside high-speed reverse
// - Frame sync 64 kHz in high-speed reverse
// - First output driven only when enable bit set
// - Ratio selects come from serial writes
// - Exactly one of six operating modes
// - Both synthesized outputs derive from reference
// - Serial input sampled at shift rising edge
// - Strap high takes mode from register (code 5 is slave), strap low forces slave
// - Lock high only while chosen PLLs lock
`timescale 1ns/100ps
`include "dpc_defines.svh"

module dpc_top
	import dpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic select_low_n_i,
	input wire logic shift_clk_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	input wire logic master_slave_i,
	input wire logic reference_input_i,
	input wire logic [1:0] pll_lock_i,
	output logic synth_one_o,
	output logic synth_one_oe_o,
	output logic synth_two_o,
	output logic frame_sync_o,
	output logic lock_o,
	output logic [`DPC_MODE_MSB:0] mode_o,
	output logic [`DPC_RATIO_W-1:0] ratio_one_o,
	output logic [`DPC_RATIO_W-1:0] ratio_two_o
);

	localparam logic [`DPC_SYNC_CNT_W-1:0] SYNC_HALF_SLOW =
		`DPC_SYNC_CNT_W'(`DPC_SYNC_HALF_SLOW);
	localparam logic [`DPC_SYNC_CNT_W-1:0] SYNC_HALF_FAST =
		`DPC_SYNC_CNT_W'(`DPC_SYNC_HALF_FAST);

	dpc_sp_state_t st_r;
	logic [`DPC_CNT_W-1:0] cnt_r;
	logic [`DPC_DATA_W-1:0] shreg_r;
	logic [`DPC_ADDR_W-1:0] addr_r;
	logic [`DPC_DATA_W-1:0] regs_r [`DPC_NUM_REGS];
	logic sclk_q_r;
	logic ref_q_r;
	logic serial_out_r;
	logic serial_oe_r;
	logic one_oe_r;
	logic lock_r;
	dpc_mode_t mode_r;
	logic [`DPC_SYNC_CNT_W-1:0] fs_cnt_r;
	logic fs_r;
	logic sclk_rise;
	logic sclk_fall;
	logic cmd_end;
	logic [`DPC_ADDR_W-1:0] cmd_addr;
	logic [`DPC_DATA_W-1:0] rd_word;
	logic wr_en;
	logic [`DPC_DATA_W-1:0] wr_data;
	logic [`DPC_SYNC_CNT_W-1:0] fs_half;

	dpc_div_if div_one ();
	dpc_div_if div_two ();

	// Edge detection; select high masks the port entirely
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q_r <= 1'b0;
			ref_q_r <= 1'b0;
		end else begin
			sclk_q_r <= shift_clk_i;
			ref_q_r <= reference_input_i;
		end
	end

	assign sclk_rise = !select_low_n_i && shift_clk_i && !sclk_q_r;
	assign sclk_fall = !select_low_n_i && !shift_clk_i && sclk_q_r;

	// Decode of the frame header and the write strobe
	assign cmd_end = (st_r == DPC_SP_CMD) && sclk_rise && (cnt_r == `DPC_CMD_LAST);
	assign cmd_addr = {shreg_r[1:0], serial_in_i};
	assign rd_word = regs_r[cmd_addr];
	assign wr_data = {shreg_r[`DPC_DATA_W-2:0], serial_in_i};
	assign wr_en = (st_r == DPC_SP_WDATA) && sclk_rise && (cnt_r == `DPC_DATA_LAST);

	// Serial sequencer: flag and address, then data in or out
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= DPC_SP_CMD;
			cnt_r <= '0;
			shreg_r <= '0;
			addr_r <= '0;
		end else if (select_low_n_i) begin
			st_r <= DPC_SP_CMD;
			cnt_r <= '0;
		end else begin
			unique case (st_r)
				DPC_SP_CMD: begin
					if (cmd_end) begin
						addr_r <= cmd_addr;
						cnt_r <= '0;
						if (shreg_r[2] == `DPC_RW_READ) begin
							shreg_r <= rd_word;
							st_r <= DPC_SP_RDATA;
						end else begin
							st_r <= DPC_SP_WDATA;
						end
					end else if (sclk_rise) begin
						shreg_r <= wr_data;
						cnt_r <= cnt_r + 1'b1;
					end
				end
				DPC_SP_WDATA: begin
					if (sclk_rise) begin
						shreg_r <= wr_data;
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == `DPC_DATA_LAST) begin
							st_r <= DPC_SP_DONE;
						end
					end
				end
				DPC_SP_RDATA: begin
					if (sclk_fall) begin
						shreg_r <= {shreg_r[`DPC_DATA_W-2:0], 1'b0};
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == `DPC_DATA_BITS) begin
							st_r <= DPC_SP_DONE;
						end
					end
				end
				DPC_SP_DONE: begin
					// Extra clocks ignored until select is released
				end
			endcase
		end
	end

	// Read data driver: bits leave MSB first, one per falling edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_out_r <= 1'b0;
			serial_oe_r <= 1'b0;
		end else if (select_low_n_i) begin
			serial_oe_r <= 1'b0;
		end else if ((st_r == DPC_SP_RDATA) && sclk_fall) begin
			if (cnt_r < `DPC_DATA_BITS) begin
				serial_out_r <= shreg_r[`DPC_DATA_W-1];
				serial_oe_r <= 1'b1;
			end else begin
				serial_oe_r <= 1'b0;
			end
		end
	end

	// Command registers, written only by a complete frame
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `DPC_NUM_REGS; i++) begin
				regs_r[i] <= `DPC_REG_RESET;
			end
		end else if (wr_en) begin
			regs_r[addr_r] <= wr_data;
		end
	end

	// Mode, output enable and lock source, all registered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r <= DPC_FWD_MASTER;
			one_oe_r <= 1'b0;
			lock_r <= 1'b0;
		end else begin
			mode_r <= dpc_mode_decode(regs_r[`DPC_REG_MODE][`DPC_MODE_MSB:0],
				master_slave_i);
			one_oe_r <= regs_r[`DPC_REG_OUT_CTRL][`DPC_OUT_ONE_EN_BIT];
			unique case (regs_r[`DPC_REG_LOCK_SEL][`DPC_LOCK_SEL_MSB:0])
				`DPC_LOCK_ONE: lock_r <= pll_lock_i[0];
				`DPC_LOCK_TWO: lock_r <= pll_lock_i[1];
				default: lock_r <= &pll_lock_i;
			endcase
		end
	end

	// Frame sync from a system clock divider; rate follows the mode
	assign fs_half = (mode_r == DPC_HS_REVERSE) ? SYNC_HALF_FAST : SYNC_HALF_SLOW;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fs_cnt_r <= '0;
			fs_r <= 1'b0;
		end else if (fs_cnt_r >= fs_half - 1'b1) begin
			fs_cnt_r <= '0;
			fs_r <= ~fs_r;
		end else begin
			fs_cnt_r <= fs_cnt_r + 1'b1;
		end
	end

	// Both synthesized clocks come from the reference via ratio dividers
	assign div_one.ref_rise = reference_input_i && !ref_q_r;
	assign div_two.ref_rise = reference_input_i && !ref_q_r;
	assign div_one.ratio = regs_r[`DPC_REG_RATIO_ONE];
	assign div_two.ratio = regs_r[`DPC_REG_RATIO_TWO];

	dpc_ratio_div u_div_one (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_bus(div_one)
	);

	dpc_ratio_div u_div_two (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_bus(div_two)
	);

	assign serial_out_o = serial_out_r;
	assign serial_out_oe_o = serial_oe_r;
	assign synth_one_o = div_one.clk_out;
	assign synth_one_oe_o = one_oe_r;
	assign synth_two_o = div_two.clk_out;
	assign frame_sync_o = fs_r;
	assign lock_o = lock_r;
	assign mode_o = mode_r;
	assign ratio_one_o = regs_r[`DPC_REG_RATIO_ONE];
	assign ratio_two_o = regs_r[`DPC_REG_RATIO_TWO];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence first_read_edge_s;
		(st_r == DPC_SP_RDATA) && sclk_fall && (cnt_r == '0);
	endsequence
	sequence read_header_s;
		cmd_end && (shreg_r[2] == `DPC_RW_READ);
	endsequence

	read_load_a: assert property (read_header_s |=> shreg_r == $past(rd_word))
		else $error("read shifter not loaded from addressed register");
	read_first_a: assert property (first_read_edge_s |=>
		serial_out_oe_o && serial_out_o == $past(shreg_r[`DPC_DATA_W-1]))
		else $error("first read bit wrong");
	out_edge_a: assert property ($changed(serial_out_o) |-> $past(sclk_fall))
		else $error("serial out moved off a falling edge");
	read_release_a: assert property ((st_r == DPC_SP_RDATA) && sclk_fall &&
		(cnt_r == `DPC_DATA_BITS) |=> !serial_out_oe_o ##1 !serial_out_oe_o)
		else $error("serial out not released after read");
	abort_idle_a: assert property (select_low_n_i |=> st_r == DPC_SP_CMD && !serial_out_oe_o
		&& cnt_r == '0)
		else $error("frame not abandoned");
	slow_sync_a: assert property ($changed(frame_sync_o) && $past(mode_r) != DPC_HS_REVERSE
		|-> $past(fs_cnt_r) == SYNC_HALF_SLOW - 1'b1)
		else $error("slow sync period wrong");
	// Entering the fast rate with a high count wraps at once; that short half is skipped
	fast_sync_a: assert property ($changed(frame_sync_o) && $past(mode_r) == DPC_HS_REVERSE
		&& $past(mode_r, 2) == DPC_HS_REVERSE
		&& $past(fs_cnt_r, 2) == $past(fs_cnt_r) - 1'b1
		|-> $past(fs_cnt_r) == SYNC_HALF_FAST - 1'b1)
		else $error("fast sync period wrong");
	one_enable_a: assert property (wr_en && addr_r == `DPC_REG_OUT_CTRL
		|=> ##1 synth_one_oe_o == $past(wr_data[`DPC_OUT_ONE_EN_BIT], 2))
		else $error("first output enable not following its bit");
	ratio_write_a: assert property (wr_en && addr_r == `DPC_REG_RATIO_ONE
		|=> ratio_one_o == $past(wr_data))
		else $error("ratio write lost");
	slave_strap_a: assert property (!master_slave_i |=> mode_o == DPC_SLAVE)
		else $error("strap low did not force slave");
	mode_legal_a: assert property (mode_o <= DPC_SLAVE)
		else $error("illegal mode code");
	lock_both_a: assert property (regs_r[`DPC_REG_LOCK_SEL][`DPC_LOCK_SEL_MSB:0]
		== `DPC_LOCK_BOTH && !(&pll_lock_i) |=> !lock_o)
		else $error("lock high while a PLL unlocked");
	sample_rise_a: assert property (sclk_rise && st_r == DPC_SP_WDATA
		|=> shreg_r[0] == $past(serial_in_i))
		else $error("serial in not sampled at rising edge");

endmodule : dpc_top

// ### bench/dpc_host_model.sv
/*
 * Behavioural serial host that drives the control port of the clock block.
 * Assumes the bench calls frame() and that every shift level holds two or more clk_i cycles.
 */
`timescale 1ns/100ps

module dpc_host_model (
	input wire logic clk_i,
	input wire logic serial_out_i,
	input wire logic serial_out_oe_i,
	output logic select_low_n_o,
	output logic shift_clk_o,
	output logic serial_in_o
);
	// Idle: select pulled high, shift clock still
	initial begin
		select_low_n_o = 1'b1;
		shift_clk_o = 1'b0;
		serial_in_o = 1'b0;
	end

	// One frame of nbits; sel_n high sends the clocks with the port unselected
	task automatic frame(input logic [11:0] bits, input int half, input int nbits,
			input logic sel_n, output logic [7:0] rdata, output logic [7:0] oe_seen,
			output logic oe_end);
		logic rd;
		rd = bits[11];
		rdata = 8'h00;
		oe_seen = 8'h00;
		@(negedge clk_i);
		select_low_n_o = sel_n;
		for (int i = 0; i < nbits; i++) begin
			// Line is not held during read data, so toggle it to expose stale sampling
			serial_in_o = (rd && i > 3) ? ~serial_in_o : bits[11 - i];
			shift_clk_o = 1'b0;
			repeat (half) @(negedge clk_i);
			shift_clk_o = 1'b1;
			if (i > 3) begin
				rdata = {rdata[6:0], serial_out_i};
				oe_seen = {oe_seen[6:0], serial_out_oe_i};
			end
			repeat (half) @(negedge clk_i);
		end
		shift_clk_o = 1'b0;
		repeat (half) @(negedge clk_i);
		oe_end = serial_out_oe_i;
		select_low_n_o = 1'b1;
		serial_in_o = ~serial_in_o;
		repeat (2) @(negedge clk_i);
	endtask : frame
endmodule : dpc_host_model

// ### bench/tb_dpc_top.sv
/*
 * Self-checking bench for dpc_top: registers, modes, sync, gating, lock, dividers.
 * Assumes dpc_host_model acts as the serial host.
 */
`timescale 1ns/100ps
`include "dpc_defines.svh"

module tb_dpc_top
	import dpc_pkg::*;
;
	localparam int HALF_SLOW = 1000000000 / 40 / (2 * 8000);
	localparam int HALF_FAST = 1000000000 / 40 / (2 * 64000);
	logic clk_i, rst_i, sel_n, shclk, serial_in_pin, serial_out_pin, sdo_oe, ms, ref_in;
	logic s1, s1_oe, s2, fsync, lock, s1q, s2q, oq, oeq, shq1, shq2;
	logic [1:0] lock_in;
	logic [2:0] mode;
	logic [7:0] rat1, rat2;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int t1 = 0;
	int t2 = 0;

	dpc_top u_dpc_top (.clk_i(clk_i), .rst_i(rst_i), .select_low_n_i(sel_n),
		.shift_clk_i(shclk), .serial_in_i(serial_in_pin), .serial_out_o(serial_out_pin),
		.serial_out_oe_o(sdo_oe), .master_slave_i(ms), .reference_input_i(ref_in),
		.pll_lock_i(lock_in), .synth_one_o(s1), .synth_one_oe_o(s1_oe),
		.synth_two_o(s2), .frame_sync_o(fsync), .lock_o(lock), .mode_o(mode),
		.ratio_one_o(rat1), .ratio_two_o(rat2));
	dpc_host_model u_dpc_host_model (.clk_i(clk_i), .serial_out_i(serial_out_pin),
		.serial_out_oe_i(sdo_oe), .select_low_n_o(sel_n), .shift_clk_o(shclk),
		.serial_in_o(serial_in_pin));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	// Read data may move only one cycle after a shift fall; also counts divider toggles
	always @(posedge clk_i) begin
		cycles++;
		if (!rst_i && oeq && sdo_oe && serial_out_pin !== oq && !(shq1 === 1'b0 && shq2 === 1'b1)) begin
			check(serial_out_pin, oq);
		end
		if (s1 !== s1q) t1++;
		if (s2 !== s2q) t2++;
		{oq, oeq, shq2, shq1, s1q, s2q} = {serial_out_pin, sdo_oe, shq1, shclk, s1, s2};
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d, input int half);
		logic [7:0] r, o;
		logic e;
		u_dpc_host_model.frame({1'b0, a, d}, half, 12, 1'b0, r, o, e);
	endtask : wr

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] r, o;
		logic e;
		u_dpc_host_model.frame({1'b1, a, 8'h00}, 3, 12, 1'b0, r, o, e);
		check(r, exp);
		check(o, 8'hFF);
		check(e, 1'b0);
	endtask : rd_chk

	task automatic test_regs();
		for (int a = 1; a < 8; a++) begin
			wr(3'(a), 8'hA5 ^ 8'(a), (a % 2) ? 2 : 6);
			rd_chk(3'(a), 8'hA5 ^ 8'(a));
		end
		check(rat1, 8'hA4);
		check(rat2, 8'hA7);
	endtask : test_regs

	task automatic test_modes();
		for (int m = 0; m < 8; m++) begin
			wr(3'h0, 8'(m), 2);
			check(mode, (m < 6) ? m : 0);
		end
		ms = 1'b0;
		repeat (2) @(negedge clk_i);
		check(mode, 3'h5);
		ms = 1'b1;
	endtask : test_modes

	task automatic test_ignore();
		logic [7:0] r, o;
		logic e;
		wr(3'h4, 8'h01, 2);
		check(s1_oe, 1'b1);
		wr(3'h4, 8'hFE, 2);
		check(s1_oe, 1'b0);
		wr(3'h1, 8'h5A, 2);
		u_dpc_host_model.frame({4'h1, 8'hC3}, 2, 12, 1'b1, r, o, e);
		u_dpc_host_model.frame({4'h1, 8'hC3}, 2, 8, 1'b0, r, o, e);
		check(rat1, 8'h5A);
		u_dpc_host_model.frame({4'h9, 8'h00}, 2, 6, 1'b0, r, o, e);
		check(sdo_oe, 1'b0);
		rd_chk(3'h1, 8'h5A);
	endtask : test_ignore

	task automatic test_lock();
		for (int s = 0; s < 4; s++) begin
			wr(3'h3, 8'(s), 2);
			for (int l = 0; l < 4; l++) begin
				lock_in = 2'(l);
				repeat (2) @(negedge clk_i);
				check(lock, (s == 1) ? l % 2 : (s == 2) ? l / 2 : l / 3);
			end
		end
		lock_in = 2'h3;
	endtask : test_lock

	// Skips the first, possibly partial, half period after a mode change
	task automatic sync_half(input int exp);
		logic s;
		int n;
		for (int k = 0; k < 2; k++) begin
			s = fsync;
			n = 0;
			while (fsync === s && n < 5000) begin
				@(negedge clk_i);
				n++;
			end
		end
		check(n, exp);
	endtask : sync_half

	task automatic test_sync();
		wr(3'h0, 8'h00, 2);
		sync_half(HALF_SLOW);
		wr(3'h0, 8'h04, 2);
		sync_half(HALF_FAST);
		wr(3'h0, 8'h05, 2);
		sync_half(HALF_SLOW);
	endtask : test_sync

	// Second reset in mid-run, then both dividers from one reference
	task automatic test_div();
		wr(3'h4, 8'h01, 2);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		check(s1_oe, 1'b0);
		check(rat1, 8'h00);
		rst_i = 1'b0;
		wr(3'h1, 8'h01, 2);
		wr(3'h2, 8'h02, 2);
		t1 = 0;
		t2 = 0;
		repeat (12) begin
			ref_in = 1'b1;
			repeat (2) @(negedge clk_i);
			ref_in = 1'b0;
			repeat (2) @(negedge clk_i);
		end
		repeat (4) @(negedge clk_i);
		check(t1, 6);
		check(t2, 4);
	endtask : test_div

	// Main sequence
	initial begin
		rst_i = 1'b1;
		ms = 1'b1;
		ref_in = 1'b0;
		lock_in = 2'h3;
		repeat (5) @(negedge clk_i);
		check({sdo_oe, s1_oe, lock, mode, rat1}, 14'h0000);
		rst_i = 1'b0;
		test_regs();
		test_modes();
		test_ignore();
		test_lock();
		test_sync();
		test_div();
		conclude();
	end
endmodule : tb_dpc_top
